// ===== verilog/hcd_datapath.sv
`timescale 1ns/1ps
`include "hcd_defines.svh"

module hcd_datapath #(
    parameter int TEMP_TIMEOUT_CYC = `HCD_TEMP_TIMEOUT_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic signed [15:0] factory_compensated_sample_in,
    input wire logic sample_valid_in,
    input wire logic signed [15:0] temperature_in,
    input wire logic temperature_valid_in,
    input wire logic [9:0] offset_const_coeff_in,
    input wire logic [6:0] offset_linear_coeff_in,
    input wire logic [11:0] gain_const_coeff_in,
    input wire logic [8:0] gain_linear_coeff_in,
    input wire logic [7:0] gain_quadratic_coeff_in,
    input wire logic [7:0] filter_rate_in,
    input wire logic [1:0] filter_order_in,
    input wire logic prog_mode_in,
    input wire logic span_wr_in,
    input wire logic [2:0] span_data_in,
    input wire logic msg_start_in,
    output logic [15:0] field_value_out,
    output logic [15:0] temperature_value_out,
    output logic field_update_out,
    output logic saturated_out,
    output logic [15:0] msg_field_out,
    output logic [2:0] magnetic_span_out,
    output logic span_err_out,
    output logic temp_stale_out,
    output logic [7:0] filter_rate_out
);
    localparam int TMO_W = $clog2(TEMP_TIMEOUT_CYC + 1);

    if (TEMP_TIMEOUT_CYC < 2) begin : g_bad
        $error("hcd_datapath: TEMP_TIMEOUT_CYC too small");
    end

    hcd_pkg::hcd_state_t state_q;
    hcd_pkg::hcd_state_t state_d;

    logic signed [19:0] x_q;
    logic signed [15:0] t_q;
    logic signed [19:0] offs_q;
    logic signed [15:0] gain_q;
    logic signed [35:0] prod_q;
    logic [15:0] field_q;
    logic [15:0] temp_q;
    logic [15:0] msg_q;
    logic [2:0] span_q;
    logic span_err_q;
    logic upd_q;
    logic sat_q;
    logic stale_q;
    logic [TMO_W-1:0] tmo_q;
    logic [7:0] rate_q;

    hcd_smp_if #(.W(16)) filt_if ();

    // Filter runs on the factory-compensated stream
    hcd_lpf #(
        .W(16),
        .SHIFT(`HCD_LPF_SHIFT)
    ) u_lpf (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .x_in(factory_compensated_sample_in),
        .x_valid_in(sample_valid_in),
        .order_in(filter_order_in),
        .decim_in(rate_q),
        .out_if(filt_if.src)
    );

    // Offset polynomial terms
    wire signed [9:0] ofs_k0 = offset_const_coeff_in;
    wire signed [6:0] ofs_k1 = offset_linear_coeff_in;
    wire signed [22:0] ofs_k1_prod = ofs_k1 * t_q;
    wire signed [19:0] ofs_k0_term = 20'(ofs_k0) <<< `HCD_OFS_K0_SHIFT;
    wire signed [19:0] ofs_k1_term = 20'(ofs_k1_prod >>> `HCD_OFS_K1_SHIFT);
    wire signed [19:0] offs_d = x_q + ofs_k0_term + ofs_k1_term;

    // Gain polynomial terms
    wire signed [11:0] gain_k0 = gain_const_coeff_in;
    wire signed [8:0] gain_k1 = gain_linear_coeff_in;
    wire signed [7:0] gain_k2 = gain_quadratic_coeff_in;
    wire signed [12:0] gain_k0_b = 13'(gain_k0) + `HCD_GAIN_K0_BIAS;
    wire signed [9:0] gain_k1_b = 10'(gain_k1) + `HCD_GAIN_K1_BIAS;
    wire signed [25:0] gain_k1_prod = gain_k1_b * t_q;
    wire signed [31:0] t_sq = t_q * t_q;
    wire signed [39:0] gain_k2_prod = gain_k2 * t_sq;
    wire signed [15:0] gain_k1_term = 16'(gain_k1_prod >>> `HCD_GAIN_K1_SHIFT);
    wire signed [15:0] gain_k2_term = 16'(gain_k2_prod >>> `HCD_GAIN_K2_SHIFT);
    wire signed [15:0] gain_d = 16'(gain_k0_b) + gain_k1_term + gain_k2_term;

    // Sum times gain, gain carries a fixed fraction point
    wire signed [35:0] prod_d = offs_q * gain_q;
    wire signed [25:0] scaled = prod_q[35:`HCD_GAIN_FRAC];
    wire signed [15:0] sat_val;
    wire sat_ovf;

    hcd_sat #(
        .IN_W(26),
        .OUT_W(16)
    ) u_sat (
        .val_in(scaled),
        .val_out(sat_val),
        .ovf_out(sat_ovf)
    );

    wire take = (state_q == hcd_pkg::ST_IDLE) && filt_if.valid;
    wire store = (state_q == hcd_pkg::ST_STORE);
    wire msg_take = msg_start_in && !prog_mode_in;
    wire span_take = span_wr_in && prog_mode_in;
    wire span_bad = (span_data_in == `HCD_SPAN_RESERVED);
    wire tmo_hit = (tmo_q == TMO_W'(TEMP_TIMEOUT_CYC));
    // A message starting on the store edge must see the new value
    wire [15:0] latest = store ? sat_val : field_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            hcd_pkg::ST_IDLE: begin
                if (filt_if.valid) begin
                    state_d = hcd_pkg::ST_TERMS;
                end
            end
            hcd_pkg::ST_TERMS: begin
                state_d = hcd_pkg::ST_MULT;
            end
            hcd_pkg::ST_MULT: begin
                state_d = hcd_pkg::ST_STORE;
            end
            default: begin
                state_d = hcd_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= hcd_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Samples arriving while busy are dropped; the filter rate is far below
    // the four-cycle evaluation time so this never happens in service.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            x_q <= '0;
            t_q <= '0;
        end else if (take) begin
            x_q <= 20'(filt_if.data);
            t_q <= temp_q;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            offs_q <= '0;
            gain_q <= '0;
            prod_q <= '0;
        end else begin
            if (state_q == hcd_pkg::ST_TERMS) begin
                offs_q <= offs_d;
                gain_q <= gain_d;
            end
            if (state_q == hcd_pkg::ST_MULT) begin
                prod_q <= prod_d;
            end
        end
    end

    // Volatile result registers start at the negative overflow value
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            field_q <= `HCD_NEG_OVF;
            upd_q <= 1'b0;
            sat_q <= 1'b0;
        end else begin
            upd_q <= store;
            if (store) begin
                field_q <= sat_val;
                sat_q <= sat_ovf;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            msg_q <= `HCD_NEG_OVF;
        end else if (msg_take) begin
            msg_q <= latest;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            temp_q <= `HCD_NEG_OVF;
        end else if (temperature_valid_in) begin
            temp_q <= temperature_in & `HCD_TEMP_RES_MASK;
        end
    end

    // Watchdog on the temperature refresh; the flag drops on the next update
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tmo_q <= '0;
            stale_q <= 1'b0;
        end else if (temperature_valid_in) begin
            tmo_q <= '0;
            stale_q <= 1'b0;
        end else if (tmo_hit) begin
            stale_q <= 1'b1;
        end else begin
            tmo_q <= tmo_q + TMO_W'(1);
        end
    end

    // Configuration only changes in programming mode
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            span_q <= `HCD_SPAN_RESET;
            span_err_q <= 1'b0;
            rate_q <= `HCD_FS_RESET;
        end else if (span_take) begin
            span_err_q <= span_bad;
            rate_q <= filter_rate_in;
            if (!span_bad) begin
                span_q <= span_data_in;
            end
        end
    end

    assign field_value_out = field_q;
    assign temperature_value_out = temp_q;
    assign field_update_out = upd_q;
    assign saturated_out = sat_q;
    assign msg_field_out = msg_q;
    assign magnetic_span_out = span_q;
    assign span_err_out = span_err_q;
    assign temp_stale_out = stale_q;
    assign filter_rate_out = rate_q;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_result_timing: assert property (
        take |-> ##4 field_update_out
    ) else $error("result not stored four cycles after filtered sample");

    a_field_hold: assert property (
        !store |=> $stable(field_value_out)
    ) else $error("field value changed outside a store");

    a_sat_extreme: assert property (
        field_update_out && saturated_out |->
            (field_value_out == `HCD_POS_MAX) || (field_value_out == `HCD_NEG_OVF)
    ) else $error("saturated result is not an extreme value");

    a_msg_latest: assert property (
        msg_take |=> msg_field_out == field_value_out
    ) else $error("message did not take latest field value");

    a_temp_hold: assert property (
        !temperature_valid_in |=> $stable(temperature_value_out)
    ) else $error("temperature value changed without update");

    a_temp_res: assert property (
        (temperature_value_out & ~`HCD_TEMP_RES_MASK) == 16'h0000
    ) else $error("temperature value has sub-resolution bits");

    a_span_legal: assert property (
        magnetic_span_out != `HCD_SPAN_RESERVED
    ) else $error("reserved span code held");

    a_span_prog: assert property (
        !prog_mode_in |=> $stable(magnetic_span_out) && $stable(filter_rate_out)
    ) else $error("configuration changed outside programming mode");

    a_stale_flag: assert property (
        tmo_hit && !temperature_valid_in |=>
            temp_stale_out ##1 (temp_stale_out || $past(temperature_valid_in))
    ) else $error("missing temperature refresh not flagged");

    a_temp_latch: assert property (
        take |=> t_q == $past(temperature_value_out) ##2 $stable(t_q)
    ) else $error("evaluation used wrong temperature");
endmodule

// ===== pkg/hcd_defines.svh
`ifndef HCD_DEFINES_SVH
`define HCD_DEFINES_SVH

// Register reset image and saturation limits
`define HCD_NEG_OVF 16'h8000
`define HCD_POS_MAX 16'h7fff
// Only the upper 12 bits of the temperature carry real resolution
`define HCD_TEMP_RES_MASK 16'hfff0

// Magnetic span codes
`define HCD_SPAN_RESERVED 3'h0
`define HCD_SPAN_RESET 3'h1

// Filter order codes, rate reset value and section shift
`define HCD_ORDER_BYPASS 2'h0
`define HCD_ORDER_FIRST 2'h1
`define HCD_FS_RESET 8'h00
`define HCD_LPF_SHIFT 3

// Fixed-point alignment of the polynomial terms
`define HCD_OFS_K0_SHIFT 6
`define HCD_OFS_K1_SHIFT 10
`define HCD_GAIN_K0_BIAS 13'sh0059
`define HCD_GAIN_K1_BIAS 10'sh06c
`define HCD_GAIN_K1_SHIFT 14
`define HCD_GAIN_K2_SHIFT 29
`define HCD_GAIN_FRAC 10

// Temperature refresh deadline
`define HCD_TEMP_TIMEOUT_NS 100000000
`define HCD_CLK_PERIOD_NS 4
`define HCD_TEMP_TIMEOUT_CYC (`HCD_TEMP_TIMEOUT_NS / `HCD_CLK_PERIOD_NS)

`endif

// ===== pkg/hcd_pkg.sv
package hcd_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_TERMS,
        ST_MULT,
        ST_STORE
    } hcd_state_t;

endpackage

// ===== pkg/hcd_smp_if.sv
`timescale 1ns/1ps
interface hcd_smp_if #(
    parameter int W = 16
);
    logic signed [W-1:0] data;
    logic valid;

    modport src (output data, output valid);
    modport snk (input data, input valid);
endinterface

// ===== verilog/hcd_sat.sv
`timescale 1ns/1ps
module hcd_sat #(
    parameter int IN_W = 26,
    parameter int OUT_W = 16
) (
    input wire logic signed [IN_W-1:0] val_in,
    output logic signed [OUT_W-1:0] val_out,
    output logic ovf_out
);
    if (IN_W <= OUT_W) begin : g_bad
        $error("hcd_sat: IN_W must exceed OUT_W");
    end

    wire [IN_W-OUT_W:0] hi = val_in[IN_W-1:OUT_W-1];
    wire fits = (&hi) || (~|hi);
    wire [OUT_W-1:0] lim_pos = {1'b0, {(OUT_W-1){1'b1}}};
    wire [OUT_W-1:0] lim_neg = {1'b1, {(OUT_W-1){1'b0}}};

    // Clamp instead of wrapping
    assign ovf_out = !fits;
    assign val_out = fits ? val_in[OUT_W-1:0] : (val_in[IN_W-1] ? lim_neg : lim_pos);
endmodule

// ===== verilog/hcd_lpf.sv
`timescale 1ns/1ps
`include "hcd_defines.svh"
module hcd_lpf #(
    parameter int W = 16,
    parameter int SHIFT = `HCD_LPF_SHIFT
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic signed [W-1:0] x_in,
    input wire logic x_valid_in,
    input wire logic [1:0] order_in,
    input wire logic [7:0] decim_in,
    hcd_smp_if.src out_if
);
    localparam int AW = W + SHIFT + 1;

    if (SHIFT < 1 || SHIFT > 8) begin : g_bad
        $error("hcd_lpf: SHIFT out of range");
    end

    // Guard bit keeps the stage difference from wrapping
    logic signed [AW-1:0] chain [3];
    logic [7:0] cnt_q;
    wire emit = x_valid_in && (cnt_q == decim_in);
    wire signed [AW-1:0] sel = (order_in == `HCD_ORDER_BYPASS) ? chain[0] :
                               (order_in == `HCD_ORDER_FIRST) ? chain[1] : chain[2];

    assign chain[0] = {x_in[W-1], x_in, {SHIFT{1'b0}}};

    // Up to two cascaded first-order sections
    for (genvar i = 0; i < 2; i++) begin : g_stage
        logic signed [AW-1:0] acc_q;
        always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                acc_q <= '0;
            end else if (x_valid_in) begin
                acc_q <= acc_q + ((chain[i] - acc_q) >>> SHIFT);
            end
        end
        assign chain[i+1] = acc_q;
    end

    // Output rate is the input rate divided by decim_in + 1
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
        end else if (emit) begin
            cnt_q <= '0;
        end else if (x_valid_in) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            out_if.data <= '0;
            out_if.valid <= 1'b0;
        end else begin
            out_if.valid <= emit;
            if (emit) begin
                out_if.data <= sel[W+SHIFT-1:SHIFT];
            end
        end
    end
endmodule

// ===== bench/hcd_fe_model.sv
`timescale 1ns/1ps
module hcd_fe_model (
    input wire logic clk_in,
    output logic [15:0] sample_out,
    output logic sample_valid_out,
    output logic [15:0] temp_out,
    output logic temp_valid_out,
    output logic msg_start_out
);
    initial begin
        sample_out = 16'h0000;
        sample_valid_out = 1'b0;
        temp_out = 16'h0000;
        temp_valid_out = 1'b0;
        msg_start_out = 1'b0;
    end
    // Released words turn to their inverse so a late read never sees the old value
    task automatic send_sample(input logic [15:0] x);
        @(posedge clk_in);
        #1;
        sample_out = x;
        sample_valid_out = 1'b1;
        @(posedge clk_in);
        #1;
        sample_valid_out = 1'b0;
        sample_out = ~x;
    endtask
    task automatic send_temp(input logic [15:0] t);
        @(posedge clk_in);
        #1;
        temp_out = t;
        temp_valid_out = 1'b1;
        @(posedge clk_in);
        #1;
        temp_valid_out = 1'b0;
        temp_out = ~t;
    endtask
    task automatic start_msg();
        @(posedge clk_in);
        #1;
        msg_start_out = 1'b1;
        @(posedge clk_in);
        #1;
        msg_start_out = 1'b0;
    endtask
endmodule

// ===== bench/hcd_datapath_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module hcd_datapath_tb;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [15:0] smp, tmp;
    logic smp_v, tmp_v, msg;
    logic [9:0] ofs_k0 = '0;
    logic [6:0] ofs_k1 = '0;
    logic [11:0] gain_k0 = '0;
    logic [8:0] gain_k1 = '0;
    logic [7:0] gain_k2 = '0;
    logic [7:0] rate = '0;
    logic [1:0] order = 2'h0;
    logic prog = 1'b0;
    logic wr = 1'b0;
    logic [2:0] span = 3'h0;
    logic [15:0] fv, tv, mf;
    logic upd, sat, serr, stale;
    logic [2:0] span_o;
    logic [7:0] rate_o;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [15:0] tx[5] = '{16'h1234, 16'h0800, 16'hf000, 16'h7000, 16'h9000};
    logic [15:0] tt[5] = '{16'h0000, 16'h4000, 16'hc000, 16'h0000, 16'h0000};
    logic [15:0] cf[5][5] = '{'{16'h0, 16'h0, 16'h03a7, 16'hff94, 16'h0},
        '{16'h3, 16'hfffb, 16'h0064, 16'h0014, 16'h0032},
        '{16'hfff9, 16'h9, 16'hfed4, 16'hffce, 16'hffec},
        '{16'h01ff, 16'h0, 16'h07ff, 16'h0, 16'h0},
        '{16'hfe00, 16'h0, 16'h07ff, 16'h0, 16'h0}};

    hcd_fe_model i_fe (.clk_in(clk_in), .sample_out(smp), .sample_valid_out(smp_v),
        .temp_out(tmp), .temp_valid_out(tmp_v), .msg_start_out(msg));
    hcd_datapath #(.TEMP_TIMEOUT_CYC(20)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .factory_compensated_sample_in(smp), .sample_valid_in(smp_v),
        .temperature_in(tmp), .temperature_valid_in(tmp_v),
        .offset_const_coeff_in(ofs_k0), .offset_linear_coeff_in(ofs_k1),
        .gain_const_coeff_in(gain_k0), .gain_linear_coeff_in(gain_k1),
        .gain_quadratic_coeff_in(gain_k2), .filter_rate_in(rate), .filter_order_in(order),
        .prog_mode_in(prog), .span_wr_in(wr), .span_data_in(span), .msg_start_in(msg),
        .field_value_out(fv), .temperature_value_out(tv), .field_update_out(upd),
        .saturated_out(sat), .msg_field_out(mf), .magnetic_span_out(span_o),
        .span_err_out(serr), .temp_stale_out(stale), .filter_rate_out(rate_o));

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Mirrors the fixed-point scaling chosen for the compensation arithmetic
    function automatic logic [15:0] expv(input logic [15:0] x, input logic [15:0] t);
        longint o, g, p, v;
        v = longint'($signed(t));
        o = longint'($signed(x)) + (longint'($signed(ofs_k0)) <<< 6)
            + ((longint'($signed(ofs_k1)) * v) >>> 10);
        g = longint'($signed(gain_k0)) + 89
            + (((longint'($signed(gain_k1)) + 108) * v) >>> 14)
            + ((longint'($signed(gain_k2)) * v * v) >>> 29);
        p = (o * g) >>> 10;
        if (p > 32767)
            return 16'h7fff;
        if (p < -32768)
            return 16'h8000;
        return p[15:0];
    endfunction

    task automatic wait_upd(output int n);
        n = 0;
        repeat (8) begin
            @(posedge clk_in);
            #1;
            if (upd === 1'b1)
                n++;
        end
    endtask

    task automatic set_span(input logic p, input logic [2:0] c, input logic [7:0] r);
        @(posedge clk_in);
        #1;
        prog = p;
        span = c;
        rate = r;
        wr = 1'b1;
        @(posedge clk_in);
        #1;
        wr = 1'b0;
        prog = 1'b0;
    endtask

    initial begin
        int n;
        logic [15:0] e;
        logic [2:0] sp;
        repeat (2) @(posedge clk_in);
        #1;
        rst_n_in = 1'b1;
        `CHK(fv, 16'h8000)
        `CHK(tv, 16'h8000)
        `CHK(span_o, 3'h1)
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            {ofs_k0, ofs_k1, gain_k0, gain_k1, gain_k2} = {cf[i][0][9:0], cf[i][1][6:0],
                cf[i][2][11:0], cf[i][3][8:0], cf[i][4][7:0]};
            i_fe.send_temp(tt[i]);
            @(posedge clk_in);
            #1;
            `CHK(tv, tt[i] & 16'hfff0)
            i_fe.send_sample(tx[i]);
            wait_upd(n);
            e = expv(tx[i], tt[i] & 16'hfff0);
            `CHK(n, 1)
            `CHK(fv, e)
            `CHK(sat, i >= 3)
            prog = (i == 4);
            i_fe.start_msg();
            prog = 1'b0;
            @(posedge clk_in);
            #1;
            `CHK(mf, (i == 4) ? 16'h7fff : e)
        end
        $display("test compensation done");
        sp = 3'h1;
        for (int c = 0; c < 8; c++) begin
            set_span(1'b1, c[2:0], 8'(c));
            if (c != 0)
                sp = c[2:0];
            `CHK(span_o, sp)
            `CHK(serr, c == 0)
            `CHK(rate_o, 8'(c))
        end
        set_span(1'b0, 3'h2, 8'h09);
        `CHK(span_o, 3'h7)
        `CHK(rate_o, 8'h07)
        $display("test span done");
        set_span(1'b1, 3'h3, 8'h01);
        {ofs_k0, ofs_k1, gain_k0, gain_k1, gain_k2} = {10'h0, 7'h0, 12'h3a7, 9'h194, 8'h0};
        e = 16'h0;
        for (int k = 0; k < 4; k++) begin
            i_fe.send_sample(16'h0100);
            wait_upd(n);
            e += 16'(n);
        end
        `CHK(e, 16'h0002)
        $display("test decimation done");
        set_span(1'b1, 3'h3, 8'h00);
        order = 2'h2;
        // Long run of one value lets the first section settle within an LSB and the cascade within two
        repeat (100) i_fe.send_sample(16'h0100);
        repeat (8) @(posedge clk_in);
        i_fe.send_sample(16'h0100);
        wait_upd(n);
        `CHK(n, 1)
        `CHK(fv >= 16'h00fe && fv <= 16'h0100, 1'b1)
        order = 2'h1;
        i_fe.send_sample(16'h0100);
        wait_upd(n);
        `CHK(fv >= 16'h00ff && fv <= 16'h0100, 1'b1)
        order = 2'h2;
        i_fe.send_sample(16'h1100);
        wait_upd(n);
        `CHK(fv >= 16'h00fe && fv <= 16'h0100, 1'b1)
        $display("test filter done");
        i_fe.send_temp(16'h0123);
        repeat (20) @(posedge clk_in);
        #1;
        `CHK(stale, 1'b0)
        repeat (1) @(posedge clk_in);
        #1;
        `CHK(stale, 1'b1)
        i_fe.send_temp(16'h0456);
        @(posedge clk_in);
        #1;
        `CHK(stale, 1'b0)
        `CHK(tv, 16'h0450)
        $display("test temperature done");
        close_out();
    end
endmodule
